// >>> rtl/priv_ser_ctrl.sv
// Privilege check and serialization control with an AXI4-Lite slave.
// What this block does
// - Current level is two bits, zero most privileged, three least.
// - System operations away from level zero raise a privileged fault, unless an interrupt takes the same slot.
// - Application operations never raise a privilege fault.
// - Level changes only on interruption entry and on return.
// - Written values are read back by later instruction groups.
// - Application effects show at group end, listed exceptions excluded.
// - System effects wait, yet reads return the last written value.
// - Instruction serialization commits all effects before fetch restarts.
// - Return and instruction-serialize perform instruction serialization.
// - Every interruption serializes before the handler's first group.
// - Data serialization exposes prior changes, may share a group.
// - Data-serialize and every instruction serialization serialize data.
// - Reads before serialization may return any pending or old value.
// - Different reads of pending values may each see different ones.
// - Effects may appear any time before serialization completes.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module priv_ser_ctrl
    import priv_ser_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [DW-1:0] s_axi_wdata_in,
    input wire logic [STRB_W-1:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [DW-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic insn_valid_in,
    input wire logic [3:0] insn_op_in,
    input wire logic [IDX_W-1:0] insn_idx_in,
    input wire logic [DW-1:0] insn_wdata_in,
    input wire logic group_end_in,
    input wire logic irq_in,
    output logic [CPL_W-1:0] cpl_out,
    output logic fault_out,
    output logic redirect_out,
    output logic [DW-1:0] redirect_addr_out,
    output logic fetch_restart_out,
    output logic dser_done_out,
    output logic rd_valid_out,
    output logic [DW-1:0] rd_data_out
);
    res_if rif();

    op_e op;
    logic priv_fault;
    logic take_irq;
    logic exec;
    logic rfi_ok;
    logic iser;
    logic dser;
    logic [CPL_W-1:0] cpl_q;
    logic [CPL_W-1:0] saved_cpl_q;
    logic [DW-1:0] handler_q;
    logic [DW-1:0] fault_cnt_q;
    logic [IDX_W-1:0] eff_sel_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [DW-1:0] wdata_q;
    logic [STRB_W-1:0] wstrb_q;
    logic wr_fire;
    logic [DW-1:0] status_w;
    logic [DW-1:0] rd_mux;
    logic rd_hit;
    logic [APP_IDX_W-1:0] app_idx;

    ser_resource_file u_file (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .rif(rif)
    );

    // Issue decode: faults and interrupts turn the slot into an interruption.
    assign op = op_e'(insn_op_in);
    assign priv_fault = insn_valid_in && is_system(op) &&
                        cpl_q != CPL_MOST && !irq_in;
    assign take_irq = irq_in || priv_fault;
    assign exec = insn_valid_in && !take_irq;
    assign rfi_ok = exec && op == OP_RFI;
    assign iser = rfi_ok || (exec && op == OP_SRLZ_I) ||
                  take_irq;
    assign dser = iser || (exec && op == OP_SRLZ_D);
    assign app_idx = insn_idx_in[APP_IDX_W-1:0];

    // Resource file requests; a suppressed slot writes nothing.
    assign rif.wr_en = exec && (op == OP_APP_WR || op == OP_SYS_WR);
    assign rif.wr_sys = op == OP_SYS_WR;
    assign rif.wr_idx = insn_idx_in;
    assign rif.wr_data = insn_wdata_in;
    assign rif.rd_sys = op == OP_SYS_RD;
    assign rif.rd_idx = insn_idx_in;
    assign rif.group_end = insn_valid_in && group_end_in;
    assign rif.ser_all = dser;
    assign rif.eff_sel = eff_sel_q;

    // Current level: only interruption entry and return move it.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cpl_q <= CPL_MOST;
        end else if (take_irq) begin
            cpl_q <= CPL_MOST;
        end else if (rfi_ok) begin
            cpl_q <= saved_cpl_q;
        end
    end

    // Pipeline outputs, each registered one cycle after the slot.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_out <= 1'b0;
            redirect_out <= 1'b0;
            redirect_addr_out <= HANDLER_RESET;
            fetch_restart_out <= 1'b0;
            dser_done_out <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            cpl_out <= CPL_MOST;
        end else begin
            fault_out <= priv_fault;
            redirect_out <= take_irq;
            redirect_addr_out <= handler_q;
            fetch_restart_out <= iser;
            dser_done_out <= dser;
            rd_valid_out <= exec && (op == OP_APP_RD || op == OP_SYS_RD);
            rd_data_out <= rif.rd_data;
            cpl_out <= take_irq ? CPL_MOST :
                       rfi_ok ? saved_cpl_q : cpl_q;
        end
    end

    // Fault counter shown to software.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_cnt_q <= '0;
        end else if (priv_fault) begin
            fault_cnt_q <= fault_cnt_q + DW'(1);
        end
    end

    // AXI write address and data channels, taken in either order.
    assign wr_fire = !s_axi_awready_out && !s_axi_wready_out &&
                     !s_axi_bvalid_out;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_awready_out <= 1'b1;
            awaddr_q <= '0;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_axi_awready_out <= 1'b0;
            awaddr_q <= s_axi_awaddr_in;
        end else if (wr_fire) begin
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_wready_out <= 1'b1;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_axi_wready_out <= 1'b0;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
        end else if (wr_fire) begin
            s_axi_wready_out <= 1'b1;
        end
    end

    // Write response, with an error for an unmapped or read-only offset.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (awaddr_q == REG_HANDLER ||
                awaddr_q == REG_SAVED_CPL || awaddr_q == REG_EFF_SEL) ?
                RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // Software registers; an interruption saves the level it left.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            handler_q <= HANDLER_RESET;
            saved_cpl_q <= CPL_MOST;
            eff_sel_q <= '0;
        end else begin
            if (wr_fire && awaddr_q == REG_HANDLER) begin
                handler_q <= merge(handler_q, wdata_q, wstrb_q);
            end
            if (take_irq) begin
                saved_cpl_q <= cpl_q;
            end else if (wr_fire && awaddr_q == REG_SAVED_CPL &&
                         wstrb_q[0]) begin
                saved_cpl_q <= wdata_q[CPL_W-1:0];
            end
            if (wr_fire && awaddr_q == REG_EFF_SEL && wstrb_q[0]) begin
                eff_sel_q <= wdata_q[IDX_W-1:0];
            end
        end
    end

    // Read data selection.
    assign status_w = DW'(cpl_q) |
                      (DW'(rif.sys_inflight) << ST_SYS_LSB) |
                      (DW'(rif.app_inflight) << ST_APP_LSB);
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr_in)
            REG_HANDLER: rd_mux = handler_q;
            REG_SAVED_CPL: rd_mux = DW'(saved_cpl_q);
            REG_STATUS: rd_mux = status_w;
            REG_FAULTS: rd_mux = fault_cnt_q;
            REG_EFF_SEL: rd_mux = DW'(eff_sel_q);
            REG_EFF_VAL: rd_mux = rif.eff_val;
            default: begin
                rd_mux = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // AXI read channel: answer one cycle after the address is taken.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= '0;
            s_axi_rresp_out <= RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_mux;
            s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // Checks on the issue path.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence s_sys_write;
        exec && op == OP_SYS_WR;
    endsequence

    sequence s_sys_read;
        exec && op == OP_SYS_RD;
    endsequence

    property p_data_dep;
        logic [IDX_W-1:0] idx;
        logic [DW-1:0] d;
        (s_sys_write, idx = insn_idx_in, d = insn_wdata_in) ##1
            (s_sys_read and insn_idx_in == idx) |=> rd_data_out == d;
    endproperty

    a_fault_on_level: assert property (
        insn_valid_in && is_system(op) && cpl_q != CPL_MOST && !irq_in
        |=> fault_out && redirect_out && cpl_out == CPL_MOST)
        else $error("privileged operation did not fault");
    a_app_no_fault: assert property (
        insn_valid_in && !is_system(op) |=> !fault_out)
        else $error("application operation faulted");
    a_level_change: assert property (
        cpl_q != $past(cpl_q) |-> $past(take_irq) || $past(rfi_ok))
        else $error("level changed outside entry or return");
    a_restart_clean: assert property (
        fetch_restart_out |-> rif.sys_inflight == '0 &&
        rif.app_inflight == '0)
        else $error("fetch restarted with pending effects");
    a_rfi_serial: assert property (
        rfi_ok |=> fetch_restart_out && dser_done_out &&
        cpl_out == $past(saved_cpl_q))
        else $error("return did not serialize");
    a_irq_handler: assert property (
        irq_in |=> redirect_out && fetch_restart_out &&
        redirect_addr_out == $past(handler_q))
        else $error("interruption did not serialize and redirect");
    a_dser_clean: assert property (
        exec && op == OP_SRLZ_D |=> dser_done_out && !fetch_restart_out
        && rif.sys_inflight == '0)
        else $error("data serialization left pending effects");
    a_fault_suppress: assert property (
        priv_fault |-> !rif.wr_en ##1 !rd_valid_out)
        else $error("faulting operation changed state");
    a_app_implicit: assert property (
        exec && op == OP_APP_WR && group_end_in && !APP_NOSER_MASK[app_idx]
        |=> !rif.app_inflight[$past(app_idx)])
        else $error("application effect not visible after group");
    a_data_dep: assert property (p_data_dep)
        else $error("read missed the prior write");
endmodule // priv_ser_ctrl

// >>> rtl/priv_ser_pkg.sv
// Constants, types and decode helpers for the privilege and serialization block.
package priv_ser_pkg;
    localparam int DW = 32;
    localparam int AXI_AW = 8;
    localparam int CPL_W = 2;
    localparam int NSYS = 8;
    localparam int NAPP = 4;
    localparam int IDX_W = 3;
    localparam int APP_IDX_W = 2;
    localparam int STRB_W = DW / 8;

    // Privilege levels: zero is the most privileged, three the least.
    localparam logic [CPL_W-1:0] CPL_MOST = 2'h0;
    localparam logic [CPL_W-1:0] CPL_LEAST = 2'h3;

    // Application resources whose side effects wait for explicit
    // serialization: 0 interval counter, 1 current_frame_marker, 2 user mask.
    localparam logic [NAPP-1:0] APP_NOSER_MASK = 4'h7;

    // Register byte offsets.
    localparam logic [AXI_AW-1:0] REG_HANDLER = 8'h00;
    localparam logic [AXI_AW-1:0] REG_SAVED_CPL = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_FAULTS = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_EFF_SEL = 8'h10;
    localparam logic [AXI_AW-1:0] REG_EFF_VAL = 8'h14;

    // Field positions in the status word.
    localparam int ST_SYS_LSB = 8;
    localparam int ST_APP_LSB = 16;

    localparam logic [DW-1:0] HANDLER_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations presented on the issue port, one per cycle.
    typedef enum logic [3:0] {
        OP_NOP, OP_APP, OP_APP_WR, OP_APP_RD, OP_SYS, OP_SYS_WR,
        OP_SYS_RD, OP_RFI, OP_SRLZ_I, OP_SRLZ_D
    } op_e;

    // True for operations that need privilege level zero.
    function automatic logic is_system(input op_e op);
        return op == OP_SYS || op == OP_SYS_WR || op == OP_SYS_RD ||
               op == OP_RFI || op == OP_SRLZ_I || op == OP_SRLZ_D;
    endfunction

    // Merges write data into an old word under byte strobes.
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
        input logic [DW-1:0] nw, input logic [STRB_W-1:0] strb);
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

// >>> rtl/res_if.sv
// Interface between the control logic and the resource file.
`timescale 1ns/10ps
interface res_if;
    import priv_ser_pkg::*;
    logic wr_en;
    logic wr_sys;
    logic [IDX_W-1:0] wr_idx;
    logic [DW-1:0] wr_data;
    logic rd_sys;
    logic [IDX_W-1:0] rd_idx;
    logic [DW-1:0] rd_data;
    logic group_end;
    logic ser_all;
    logic [NSYS-1:0] sys_inflight;
    logic [NAPP-1:0] app_inflight;
    logic [IDX_W-1:0] eff_sel;
    logic [DW-1:0] eff_val;

    modport ctrl(output wr_en, wr_sys, wr_idx, wr_data, rd_sys, rd_idx,
        group_end, ser_all, eff_sel,
        input rd_data, sys_inflight, app_inflight, eff_val);
    modport file(input wr_en, wr_sys, wr_idx, wr_data, rd_sys, rd_idx,
        group_end, ser_all, eff_sel,
        output rd_data, sys_inflight, app_inflight, eff_val);
endinterface

// >>> rtl/ser_resource_file.sv
// Resource file holding written values and their visible side effects.
`timescale 1ns/10ps
module ser_resource_file
    import priv_ser_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    res_if.file rif
);
    logic [DW-1:0] sys_data_q [NSYS];
    logic [DW-1:0] sys_eff_q [NSYS];
    logic [DW-1:0] app_data_q [NAPP];
    logic [DW-1:0] app_eff_q [NAPP];
    logic [APP_IDX_W-1:0] app_wr_idx;
    logic [APP_IDX_W-1:0] app_rd_idx;

    assign app_wr_idx = rif.wr_idx[APP_IDX_W-1:0];
    assign app_rd_idx = rif.rd_idx[APP_IDX_W-1:0];

    // System registers: the value is kept at once, the effect waits.
    for (genvar i = 0; i < NSYS; i++) begin : g_sys
        logic hit;
        logic [DW-1:0] nxt;
        assign hit = rif.wr_en && rif.wr_sys && rif.wr_idx == IDX_W'(i);
        assign nxt = hit ? rif.wr_data : sys_data_q[i];
        assign rif.sys_inflight[i] = sys_data_q[i] != sys_eff_q[i];
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                sys_data_q[i] <= '0;
                sys_eff_q[i] <= '0;
            end else begin
                sys_data_q[i] <= nxt;
                if (rif.ser_all) begin
                    sys_eff_q[i] <= nxt;
                end
            end
        end
    end

    // Application registers: effects follow at the end of the group, except those set in APP_NOSER_MASK.
    for (genvar j = 0; j < NAPP; j++) begin : g_app
        logic hit;
        logic [DW-1:0] nxt;
        assign hit = rif.wr_en && !rif.wr_sys &&
                     app_wr_idx == APP_IDX_W'(j);
        assign nxt = hit ? rif.wr_data : app_data_q[j];
        assign rif.app_inflight[j] = app_data_q[j] != app_eff_q[j];
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                app_data_q[j] <= '0;
                app_eff_q[j] <= '0;
            end else begin
                app_data_q[j] <= nxt;
                if (rif.ser_all ||
                    (rif.group_end && !APP_NOSER_MASK[j])) begin
                    app_eff_q[j] <= nxt;
                end
            end
        end
    end

    // Reads return the newest written value, one of the permitted ones.
    assign rif.rd_data = rif.rd_sys ? sys_data_q[rif.rd_idx] :
                         app_data_q[app_rd_idx];
    assign rif.eff_val = sys_eff_q[rif.eff_sel];
endmodule // ser_resource_file

// >>> verif/privilege_and_serialization_control_bench.sv
// Self-checking bench for the privilege and serialization control block.
`timescale 1ns/10ps
module privilege_and_serialization_control_bench;
    import priv_ser_pkg::*;
    logic clk;
    logic arst_n;
    logic [AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [DW-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
    logic insn_valid;
    logic [3:0] insn_op;
    logic [IDX_W-1:0] insn_idx;
    logic [DW-1:0] insn_wdata;
    logic group_end;
    logic irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [DW-1:0] rdata, redirect_addr, rd_data;
    logic [CPL_W-1:0] cpl;
    logic fault, redirect, fetch_restart, dser_done, rd_valid;
    logic [4:0] pl;
    logic [CPL_W-1:0] pl_cpl;
    logic [DW-1:0] pl_data, pl_addr, got;
    logic [1:0] resp;
    int n_fail = 0;
    int tests_run = 0;

    // The block under test, every input driven by the bench.
    priv_ser_ctrl uut (
        .sys_clk_in(clk), .arst_n_in(arst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .insn_valid_in(insn_valid),
        .insn_op_in(insn_op), .insn_idx_in(insn_idx),
        .insn_wdata_in(insn_wdata), .group_end_in(group_end),
        .irq_in(irq), .cpl_out(cpl), .fault_out(fault),
        .redirect_out(redirect), .redirect_addr_out(redirect_addr),
        .fetch_restart_out(fetch_restart), .dser_done_out(dser_done),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data)
    );

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short well after the scenarios should have ended.
    initial begin
        #100000;
        n_fail++;
        summarize();
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e,
        input string what);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Presents one slot as its own group and captures the next cycle.
    task automatic iss(input op_e op, input logic [IDX_W-1:0] idx,
        input logic [DW-1:0] d, input logic irq_v);
        @(posedge clk);
        insn_valid <= 1'b1;
        insn_op <= op;
        insn_idx <= idx;
        insn_wdata <= d;
        group_end <= 1'b1;
        irq <= irq_v;
        @(posedge clk);
        insn_valid <= 1'b0;
        group_end <= 1'b0;
        irq <= 1'b0;
        #1;
        pl = {fault, redirect, fetch_restart, dser_done, rd_valid};
        pl_cpl = cpl;
        pl_data = rd_data;
        pl_addr = redirect_addr;
    endtask

    // Writes one word; each channel is released when it is taken.
    task automatic axi_wr(input logic [AXI_AW-1:0] a,
        input logic [DW-1:0] d, input logic [STRB_W-1:0] s);
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Reads one word and keeps its data and response.
    task automatic axi_rd(input logic [AXI_AW-1:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // Register map: reset value, byte strobes, refused write and hole.
    task automatic t_regs();
        axi_rd(REG_HANDLER);
        chk(got, HANDLER_RESET, "handler reset");
        chk(DW'(resp), DW'(RESP_OKAY), "handler read resp");
        axi_wr(REG_HANDLER, 32'h0000_1F40, 4'hF);
        chk(DW'(resp), DW'(RESP_OKAY), "handler write resp");
        axi_wr(REG_HANDLER, 32'hFFFF_FFAA, 4'h1);
        axi_rd(REG_HANDLER);
        chk(got, 32'h0000_1FAA, "handler strobes");
        axi_wr(REG_STATUS, 32'h0000_0003, 4'hF);
        chk(DW'(resp), DW'(RESP_SLVERR), "status write");
        axi_rd(REG_STATUS);
        chk(got & 32'h3, 32'h0, "level after bus write");
        axi_rd(8'h3C);
        chk({got[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    endtask

    // Write, read back, in-flight marks and both serializations.
    task automatic t_dep();
        iss(OP_SYS_WR, 3'h2, 32'h0000_5A5A, 1'b0);
        chk(DW'(pl), 32'h0, "sys write pulses");
        iss(OP_SYS_RD, 3'h2, 32'h0, 1'b0);
        chk(DW'(pl), 32'h1, "sys read pulses");
        chk(pl_data, 32'h0000_5A5A, "sys read data");
        axi_rd(REG_STATUS);
        chk(got & 32'h000F_FF00, 32'h0000_0400, "sys inflight");
        iss(OP_SRLZ_D, 3'h0, 32'h0, 1'b0);
        chk(DW'(pl), 32'h2, "data serialize pulses");
        axi_wr(REG_EFF_SEL, 32'h2, 4'hF);
        axi_rd(REG_EFF_VAL);
        chk(got, 32'h0000_5A5A, "effect after serialize");
        iss(OP_APP_WR, 3'h3, 32'h0000_00C3, 1'b0);
        iss(OP_APP_WR, 3'h1, 32'h0000_00C1, 1'b0);
        iss(OP_APP_RD, 3'h3, 32'h0, 1'b0);
        chk(pl_data, 32'h0000_00C3, "app read data");
        axi_rd(REG_STATUS);
        chk(got & 32'h000F_FF00, 32'h0002_0000, "app inflight");
        iss(OP_SRLZ_I, 3'h0, 32'h0, 1'b0);
        chk(DW'(pl), 32'h6, "insn serialize pulses");
        axi_rd(REG_STATUS);
        chk(got & 32'h000F_FF00, 32'h0, "all committed");
    endtask

    // Writer and dependent reader in two back-to-back groups.
    task automatic t_b2b();
        @(posedge clk);
        insn_valid <= 1'b1;
        insn_op <= OP_SYS_WR;
        insn_idx <= 3'h5;
        insn_wdata <= 32'h0000_3C3C;
        group_end <= 1'b1;
        @(posedge clk);
        insn_op <= OP_SYS_RD;
        @(posedge clk);
        insn_valid <= 1'b0;
        group_end <= 1'b0;
        #1;
        chk(DW'(rd_valid), 32'h1, "next-group read valid");
        chk(rd_data, 32'h0000_3C3C, "next-group read data");
    endtask

    // Level changes, faults on every system op, interruption entry.
    task automatic t_priv();
        axi_wr(REG_SAVED_CPL, DW'(CPL_LEAST), 4'hF);
        iss(OP_RFI, 3'h0, 32'h0, 1'b0);
        chk(DW'({pl, pl_cpl}), 32'h1B, "return to least");
        for (int k = 4; k <= 9; k++) begin
            iss(op_e'(k), 3'h2, 32'h0000_DEAD, 1'b0);
            chk(DW'({pl, pl_cpl}), 32'h78, "system op fault");
            chk(pl_addr, 32'h0000_1FAA, "fault handler");
            iss(OP_RFI, 3'h0, 32'h0, 1'b0);
            chk(DW'(pl_cpl), 32'h3, "level restored");
        end
        for (int k = 0; k <= 3; k++) begin
            iss(op_e'(k), 3'h3, 32'h0000_00D3, 1'b0);
            chk(DW'({pl[4:1], pl_cpl}), 32'h3, "app op at level 3");
        end
        chk(pl_data, 32'h0000_00D3, "app read at level 3");
        axi_rd(REG_FAULTS);
        chk(got, 32'h6, "fault count");
        iss(OP_NOP, 3'h0, 32'h0, 1'b1);
        chk(DW'({pl, pl_cpl}), 32'h38, "interruption");
        axi_rd(REG_SAVED_CPL);
        chk(got & 32'h3, 32'h3, "saved level");
        iss(OP_SYS_RD, 3'h2, 32'h0, 1'b0);
        chk(pl_data, 32'h0000_5A5A, "faulted write dropped");
    endtask

    // Drives reset, checks the reset state and runs the scenarios.
    initial begin
        arst_n = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        insn_valid = 1'b0;
        insn_op = 4'h0;
        insn_idx = '0;
        insn_wdata = '0;
        group_end = 1'b0;
        irq = 1'b0;
        repeat (4) @(posedge clk);
        chk(DW'(cpl), DW'(CPL_MOST), "reset level");
        chk(DW'({awready, wready, arready, bvalid, rvalid}), 32'h1C, "reset bus");
        arst_n <= 1'b1;
        t_regs();
        t_dep();
        t_b2b();
        t_priv();
        summarize();
    end
endmodule // privilege_and_serialization_control_bench
